/* inc/fpe_consts.svh */
// constants for the flash protect and erase controller
// assumes a 32-bit apb slave with word-aligned registers
`ifndef FPE_CONSTS_SVH
`define FPE_CONSTS_SVH

// register byte offsets
`define FPE_OFS_CTRL 12'h000
`define FPE_OFS_PAGE 12'h004
`define FPE_OFS_STAT 12'h008
`define FPE_OFS_PROG 12'h00C

// control register keys and commands
`define FPE_KEY1 8'h73
`define FPE_KEY2 8'h8C
`define FPE_CMD_PERASE 8'h95
`define FPE_CMD_MERASE 8'h63
`define FPE_CMD_SECT 8'h5E

// geometry
`define FPE_PAGE_SHIFT 9
`define FPE_SECTORS 8
`define FPE_SECT_LOG 3

// status bit positions
`define FPE_ST_BUSY 0
`define FPE_ST_LOCKED 1
`define FPE_ST_ACTIVE 2
`define FPE_ST_SECT 3
`define FPE_ST_REFUSED 4
`define FPE_ST_BYPASS 5

// reset values
`define FPE_RST_PROT 8'h00
`define FPE_RST_BYTE 8'h00
`define FPE_RST_WORD 32'h0000_0000

`endif

/* inc/fpe_pkg.sv */
// types shared by the flash protect and erase controller
// assumes fpe_consts.svh supplies the numeric constants
package fpe_pkg;
    typedef enum logic [2:0] {
        FPE_LOCKED,
        FPE_KEY1_SEEN,
        FPE_KEY2_SEEN,
        FPE_PAGE_ACT,
        FPE_ERASING
    } fpe_state_e;
endpackage

/* rtl/fpe_ctrl.sv */
// flash protect, unlock, erase sequencer behind an apb slave
// assumes a flash array that pulses fl_done when an erase ends,
// dbg_access and write_protect_option in the ref_clk domain
//
// Notes on behaviour
// - option bit 0 blocks user program/erase
// - option bit 1 allows program and erase
// - reset always enters the locked state
// - matching page rewrite activates, mismatch locks
// - 95H erases page if sector unprotected
// - unknown control value relocks the controller
// - byte writes in page; control write relocks
// - mass erase only from the debug port
// - eight sectors, never smaller than a page
// - sector protect bits set-only until reset
// - sector protection clears on reset
// - 5EH maps sector protect onto page address
// - page erase covers 512 bytes to FFH
// - cpu stalls while a command erase runs, not a bypass erase
// - page erase end returns to locked
// - unlocked debug 63H starts mass erase
// - mass erase end returns to locked
// - debug ignores option bit and sector protect
// - bypass routes pins to array controls
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "fpe_consts.svh"

module fpe_ctrl #(
    parameter int MEM_BYTES = 4096
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // access origin and option bit
    input wire logic dbg_access,
    input wire logic write_protect_option,
    // cpu
    output logic cpu_stall,
    // flash array
    output logic [$clog2(MEM_BYTES)-1:0] fl_addr,
    output logic [7:0] fl_wdata,
    output logic fl_prog,
    output logic fl_page_erase,
    output logic fl_mass_erase,
    input wire logic fl_done,
    // bypass pins, asynchronous to ref_clk
    input wire logic bypass_pin,
    input wire logic byp_prog_pin,
    input wire logic byp_erase_pin,
    input wire logic [$clog2(MEM_BYTES)-1:0] byp_addr_pin,
    input wire logic [7:0] byp_data_pin
);
    localparam int ADDR_W = $clog2(MEM_BYTES);
    localparam int PAGE_W = ADDR_W - `FPE_PAGE_SHIFT;
    localparam int SECT_SHIFT = (PAGE_W > `FPE_SECT_LOG) ? PAGE_W - `FPE_SECT_LOG : 0;
    localparam int SYN_W = ADDR_W + 11;

    typedef struct packed {
        fpe_pkg::fpe_state_e fsm;
        logic [PAGE_W-1:0] page;
        logic [`FPE_SECTORS-1:0] prot;
        logic sect_sel;
        logic refused;
        logic mass;
        logic [31:0] rdata;
        logic err;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic prog;
        logic perase;
        logic merase;
        logic [SYN_W-1:0] syn1;
        logic [SYN_W-1:0] syn2;
    } fpe_regs_s;

    fpe_regs_s cur;
    fpe_regs_s next_cur;

    logic [`FPE_SECT_LOG-1:0] sect_idx;
    logic [7:0] page8;
    logic byp;
    logic byp_prog;
    logic byp_erase;
    logic [ADDR_W-1:0] byp_addr;
    logic [7:0] byp_data;
    logic wr_acc;
    logic rd_setup;
    logic [7:0] wbyte;
    logic [PAGE_W-1:0] wpage;
    logic [ADDR_W-1:0] prog_addr;
    logic sect_open;
    logic [31:0] stat_word;

    assign page8 = 8'(cur.page);
    assign sect_idx = `FPE_SECT_LOG'(page8 >> SECT_SHIFT);
    // only the second stage is read
    assign {byp, byp_prog, byp_erase, byp_addr, byp_data} = cur.syn2;
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign wbyte = pwdata[7:0];
    assign wpage = pwdata[PAGE_W-1:0];
    assign prog_addr = pwdata[ADDR_W+7:8];
    assign sect_open = dbg_access || (write_protect_option && !cur.prot[sect_idx]);

    always_comb begin
        stat_word = `FPE_RST_WORD;
        stat_word[`FPE_ST_BUSY] = (cur.fsm == fpe_pkg::FPE_ERASING);
        stat_word[`FPE_ST_LOCKED] = (cur.fsm != fpe_pkg::FPE_PAGE_ACT);
        stat_word[`FPE_ST_ACTIVE] = (cur.fsm == fpe_pkg::FPE_PAGE_ACT);
        stat_word[`FPE_ST_SECT] = cur.sect_sel;
        stat_word[`FPE_ST_REFUSED] = cur.refused;
        stat_word[`FPE_ST_BYPASS] = byp;
    end

    always_comb begin
        next_cur = cur;
        next_cur.prog = 1'b0;
        next_cur.syn1 = {bypass_pin, byp_prog_pin, byp_erase_pin, byp_addr_pin, byp_data_pin};
        next_cur.syn2 = cur.syn1;

        // read data captured in setup so it is a flop at access
        if (rd_setup) begin
            next_cur.err = 1'b0;
            next_cur.rdata = `FPE_RST_WORD;
            unique case (paddr)
                `FPE_OFS_CTRL: next_cur.rdata = `FPE_RST_WORD;
                `FPE_OFS_PAGE: next_cur.rdata = cur.sect_sel ? 32'(cur.prot) : 32'(cur.page);
                `FPE_OFS_STAT: next_cur.rdata = stat_word;
                `FPE_OFS_PROG: next_cur.rdata = {16'h0000, cur.addr[7:0], cur.wdata};
                default: next_cur.err = 1'b1;
            endcase
        end

        // writes are ignored while the array is erasing
        if (wr_acc && cur.fsm != fpe_pkg::FPE_ERASING) begin
            if (paddr == `FPE_OFS_CTRL) begin
                next_cur.sect_sel = 1'b0;
                next_cur.refused = 1'b0;
                unique case (wbyte)
                    `FPE_KEY1: begin
                        next_cur.fsm = (cur.fsm == fpe_pkg::FPE_LOCKED) ?
                            fpe_pkg::FPE_KEY1_SEEN : fpe_pkg::FPE_LOCKED;
                    end
                    `FPE_KEY2: begin
                        next_cur.fsm = (cur.fsm == fpe_pkg::FPE_KEY1_SEEN) ?
                            fpe_pkg::FPE_KEY2_SEEN : fpe_pkg::FPE_LOCKED;
                    end
                    `FPE_CMD_PERASE: begin
                        next_cur.fsm = fpe_pkg::FPE_LOCKED;
                        if (cur.fsm == fpe_pkg::FPE_PAGE_ACT && sect_open) begin
                            next_cur.fsm = fpe_pkg::FPE_ERASING;
                            next_cur.mass = 1'b0;
                            next_cur.addr = {cur.page, `FPE_PAGE_SHIFT'(0)};
                            next_cur.perase = 1'b1;
                        end else begin
                            next_cur.refused = 1'b1;
                        end
                    end
                    `FPE_CMD_MERASE: begin
                        next_cur.fsm = fpe_pkg::FPE_LOCKED;
                        if (cur.fsm == fpe_pkg::FPE_PAGE_ACT && dbg_access) begin
                            next_cur.fsm = fpe_pkg::FPE_ERASING;
                            next_cur.mass = 1'b1;
                            next_cur.merase = 1'b1;
                        end else begin
                            next_cur.refused = 1'b1;
                        end
                    end
                    `FPE_CMD_SECT: begin
                        next_cur.sect_sel = 1'b1;
                        next_cur.fsm = fpe_pkg::FPE_LOCKED;
                    end
                    default: next_cur.fsm = fpe_pkg::FPE_LOCKED;
                endcase
            end else if (paddr == `FPE_OFS_PAGE) begin
                if (cur.sect_sel) begin
                    next_cur.prot = cur.prot | wbyte;
                end else begin
                    next_cur.page = wpage;
                    if (cur.fsm == fpe_pkg::FPE_KEY2_SEEN && wpage == cur.page) begin
                        next_cur.fsm = fpe_pkg::FPE_PAGE_ACT;
                    end else if (cur.fsm == fpe_pkg::FPE_PAGE_ACT && wpage == cur.page) begin
                        next_cur.fsm = fpe_pkg::FPE_PAGE_ACT;
                    end else begin
                        next_cur.fsm = fpe_pkg::FPE_LOCKED;
                    end
                end
            end else if (paddr == `FPE_OFS_PROG) begin
                if (cur.fsm == fpe_pkg::FPE_PAGE_ACT && sect_open &&
                    prog_addr[ADDR_W-1:`FPE_PAGE_SHIFT] == cur.page) begin
                    next_cur.addr = prog_addr;
                    next_cur.wdata = wbyte;
                    next_cur.prog = 1'b1;
                    next_cur.refused = 1'b0;
                end else begin
                    next_cur.refused = 1'b1;
                end
            end
        end

        if (cur.fsm == fpe_pkg::FPE_ERASING && fl_done) begin
            next_cur.fsm = fpe_pkg::FPE_LOCKED;
            next_cur.perase = 1'b0;
            next_cur.merase = 1'b0;
        end

        // bypass drives the array from pins, page erase included
        if (byp) begin
            next_cur.addr = byp_addr;
            next_cur.wdata = byp_data;
            next_cur.prog = byp_prog;
            next_cur.perase = byp_erase;
            next_cur.merase = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cur.fsm <= fpe_pkg::FPE_LOCKED;
            cur.page <= '0;
            cur.prot <= `FPE_RST_PROT;
            cur.sect_sel <= 1'b0;
            cur.refused <= 1'b0;
            cur.mass <= 1'b0;
            cur.rdata <= `FPE_RST_WORD;
            cur.err <= 1'b0;
            cur.addr <= '0;
            cur.wdata <= `FPE_RST_BYTE;
            cur.prog <= 1'b0;
            cur.perase <= 1'b0;
            cur.merase <= 1'b0;
            cur.syn1 <= '0;
            cur.syn2 <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // zero-wait slave: every access phase completes in one cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && cur.err;
    assign prdata = cur.rdata;
    assign cpu_stall = (cur.fsm == fpe_pkg::FPE_ERASING);
    assign fl_addr = cur.addr;
    assign fl_wdata = cur.wdata;
    assign fl_prog = cur.prog;
    assign fl_page_erase = cur.perase;
    assign fl_mass_erase = cur.merase;
endmodule

/* test/fpe_ctrl_monitor.sv */
// port assertions for the flash protect and erase controller
// assumes one ref_clk domain; bound into fpe_ctrl below
`timescale 1ns/1ps
`include "fpe_consts.svh"
module fpe_ctrl_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // origin, option, bypass
    input wire logic dbg_access,
    input wire logic write_protect_option,
    input wire logic bypass_pin,
    // array side
    input wire logic cpu_stall,
    input wire logic fl_prog,
    input wire logic fl_page_erase,
    input wire logic fl_mass_erase,
    input wire logic fl_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic ctl_wr;
    // busy writes are ignored, so only idle control writes count
    assign ctl_wr = psel && penable && pwrite && paddr == `FPE_OFS_CTRL && !cpu_stall;

    chk_user_wp_block: assert property (
        ctl_wr && pwdata[7:0] == `FPE_CMD_PERASE && !dbg_access && !write_protect_option
        && !bypass_pin |=> !fl_page_erase) else $error("user erase ran with option bit 0");
    chk_user_mass_block: assert property (
        ctl_wr && pwdata[7:0] == `FPE_CMD_MERASE && !dbg_access |=> !fl_mass_erase)
        else $error("user code started a mass erase");
    chk_stall_erase: assert property (
        (fl_page_erase || fl_mass_erase) && !bypass_pin |-> cpu_stall)
        else $error("erase without cpu stall");
    chk_page_relock: assert property (
        fl_page_erase && fl_done && !bypass_pin |=> !fl_page_erase && !cpu_stall)
        else $error("page erase did not end on done");
    chk_mass_relock: assert property (
        fl_mass_erase && fl_done |=> !fl_mass_erase && !cpu_stall)
        else $error("mass erase did not end on done");
    chk_erase_hold: assert property (
        fl_page_erase && !fl_done && !bypass_pin |=> fl_page_erase)
        else $error("page erase dropped before done");
    chk_prog_pulse: assert property (
        fl_prog && !bypass_pin |=> !fl_prog) else $error("program strobe longer than one cycle");
    chk_reset_idle: assert property (
        $rose(nrst) |-> !fl_page_erase && !fl_mass_erase && !fl_prog && !cpu_stall)
        else $error("array active after reset");
endmodule

bind fpe_ctrl fpe_ctrl_monitor u_mon (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .dbg_access, .write_protect_option, .bypass_pin, .cpu_stall, .fl_prog,
    .fl_page_erase, .fl_mass_erase, .fl_done);

/* test/fpe_array_model.sv */
// behavioural flash array behind the controller
// assumes erase levels held until the done pulse it returns
`timescale 1ns/1ps
module fpe_array_model #(
    parameter int MEM_BYTES = 4096,
    parameter int DLY = 20
) (
    input wire logic ref_clk,
    input wire logic [11:0] fl_addr,
    input wire logic [7:0] fl_wdata,
    input wire logic fl_prog,
    input wire logic fl_page_erase,
    input wire logic fl_mass_erase,
    output logic fl_done
);
    logic [7:0] mem [MEM_BYTES];
    int cnt = 0;
    initial begin
        fl_done = 1'b0;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    always @(posedge ref_clk) begin
        fl_done <= 1'b0;
        if (fl_prog) begin
            mem[fl_addr] <= fl_wdata;
        end
        if ((fl_page_erase || fl_mass_erase) && !fl_done) begin
            cnt <= cnt + 1;
            if (cnt == DLY) begin
                fl_done <= 1'b1;
                cnt <= 0;
                for (int i = 0; i < MEM_BYTES; i++) begin
                    if (fl_mass_erase || i / 512 == fl_addr / 512) mem[i] <= 8'hFF;
                end
            end
        end
    end
endmodule

/* test/flash_protect_erase_ctrl_test.sv */
// self-checking bench for the flash protect and erase controller
// assumes fpe_array_model as the array; apb master lives here
`timescale 1ns/1ps
`include "fpe_consts.svh"
module flash_protect_erase_ctrl_test;
    logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic dbg_access = 1'b0, write_protect_option = 1'b1, bypass_pin = 1'b0;
    logic byp_prog_pin = 1'b0, byp_erase_pin = 1'b0, serr;
    logic [11:0] paddr = 12'h000, fl_addr, byp_addr_pin = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [7:0] fl_wdata, byp_data_pin = 8'h00;
    logic pready, pslverr, cpu_stall, fl_prog, fl_page_erase, fl_mass_erase, fl_done;
    int n_errors = 0, checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    fpe_ctrl u_dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .dbg_access, .write_protect_option, .cpu_stall, .fl_addr,
        .fl_wdata, .fl_prog, .fl_page_erase, .fl_mass_erase, .fl_done, .bypass_pin,
        .byp_prog_pin, .byp_erase_pin, .byp_addr_pin, .byp_data_pin);
    fpe_array_model u_mem (.ref_clk, .fl_addr, .fl_wdata, .fl_prog, .fl_page_erase,
        .fl_mass_erase, .fl_done);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic ctl(input logic [7:0] c);
        apb(1'b1, `FPE_OFS_CTRL, {24'h0, c});
    endtask
    task automatic st;
        apb(1'b0, `FPE_OFS_STAT, 32'h0);
    endtask
    task automatic unl(input logic [7:0] p, input logic [7:0] q);
        apb(1'b1, `FPE_OFS_PAGE, {24'h0, p});
        ctl(`FPE_KEY1);
        ctl(`FPE_KEY2);
        apb(1'b1, `FPE_OFS_PAGE, {24'h0, q});
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 50; i++) begin
            st;
            if (rdat[`FPE_ST_BUSY] === 1'b0) break;
        end
    endtask
    function automatic logic [31:0] bad(input int b, input logic [7:0] v);
        bad = 32'h0;
        for (int i = b; i < b + 512; i++) bad += {31'h0, u_mem.mem[i] !== v};
    endfunction
    task automatic t_lock;
        st;
        chk(rdat, 32'h2);
        ctl(`FPE_CMD_PERASE);
        st;
        chk(rdat & 32'h3, 32'h2);
        unl(8'h01, 8'h03);
        st;
        chk(rdat & 32'h6, 32'h2);
        unl(8'h01, 8'h01);
        ctl(8'h00);
        st;
        chk(rdat & 32'h6, 32'h2);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, serr}, 32'h1);
        $display("t_lock done");
    endtask
    task automatic t_page;
        unl(8'h02, 8'h02);
        apb(1'b1, `FPE_OFS_PROG, {12'h0, 12'h405, 8'hA5});
        apb(1'b1, `FPE_OFS_PROG, {12'h0, 12'h5FF, 8'h3C});
        st;
        chk(rdat & 32'h7, 32'h4);
        chk({24'h0, u_mem.mem[12'h405]}, 32'hA5);
        chk({24'h0, u_mem.mem[12'h5FF]}, 32'h3C);
        ctl(`FPE_CMD_PERASE);
        st;
        chk({rdat[0], cpu_stall}, 32'h3);
        wait_idle;
        chk(rdat & 32'h7, 32'h2);
        chk(bad(12'h400, 8'hFF), 32'h0);
        chk(bad(12'h200, 8'h00), 32'h0);
        $display("t_page done");
    endtask
    task automatic t_wp;
        write_protect_option <= 1'b0;
        unl(8'h01, 8'h01);
        apb(1'b1, `FPE_OFS_PROG, {12'h0, 12'h210, 8'h55});
        ctl(`FPE_CMD_PERASE);
        st;
        chk(rdat & 32'h11, 32'h10);
        chk({24'h0, u_mem.mem[12'h210]}, 32'h0);
        write_protect_option <= 1'b1;
        unl(8'h01, 8'h01);
        ctl(`FPE_CMD_MERASE);
        st;
        chk(rdat & 32'h13, 32'h12);
        dbg_access <= 1'b1;
        write_protect_option <= 1'b0;
        unl(8'h01, 8'h01);
        ctl(`FPE_CMD_PERASE);
        wait_idle;
        chk(bad(12'h200, 8'hFF), 32'h0);
        unl(8'h00, 8'h00);
        ctl(`FPE_CMD_MERASE);
        wait_idle;
        chk(rdat & 32'h7, 32'h2);
        chk(bad(12'hE00, 8'hFF), 32'h0);
        dbg_access <= 1'b0;
        write_protect_option <= 1'b1;
        $display("t_wp done");
    endtask
    task automatic t_sect;
        ctl(`FPE_CMD_SECT);
        apb(1'b1, `FPE_OFS_PAGE, 32'h08);
        apb(1'b1, `FPE_OFS_PAGE, 32'h00);
        apb(1'b0, `FPE_OFS_PAGE, 32'h0);
        chk(rdat & 32'hFF, 32'h08);
        st;
        chk(rdat & 32'h8, 32'h8);
        ctl(8'h00);
        unl(8'h03, 8'h03);
        apb(1'b1, `FPE_OFS_PROG, {12'h0, 12'h610, 8'h77});
        ctl(`FPE_CMD_PERASE);
        st;
        chk(rdat & 32'h11, 32'h10);
        chk({24'h0, u_mem.mem[12'h610]}, 32'hFF);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        ctl(`FPE_CMD_SECT);
        apb(1'b0, `FPE_OFS_PAGE, 32'h0);
        chk(rdat & 32'hFF, 32'h0);
        $display("t_sect done");
    endtask
    task automatic t_byp;
        bypass_pin <= 1'b1;
        byp_erase_pin <= 1'b1;
        byp_addr_pin <= 12'hA00;
        repeat (4) @(posedge ref_clk);
        chk({fl_page_erase, fl_addr}, 32'h1A00);
        byp_erase_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        bypass_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        $display("t_byp done");
    endtask
    task automatic summarize;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_lock;
        t_page;
        t_wp;
        t_sect;
        t_byp;
        summarize;
    end
    // a few hundred cycles expected; this is far beyond
    initial begin
        #200000;
        n_errors++;
        summarize;
    end
endmodule
